// *** design/rlnc_defines.vh ***
`ifndef RLNC_DEFINES_VH
`define RLNC_DEFINES_VH
// apb register byte offsets
`define RLNC_CTRL_OFF     12'h000
`define RLNC_INSTR_OFF    12'h004
`define RLNC_STATUS_OFF   12'h008
`define RLNC_WREG_OFF     12'h00C
`define RLNC_BANK_OFF     12'h010
`define RLNC_MEMADDR_OFF  12'h014
`define RLNC_MEMDATA_OFF  12'h018
`define RLNC_INDEX_OFF    12'h01C
// instruction word fields
`define RLNC_OPC_HI       15
`define RLNC_OPC_LO       10
`define RLNC_OPCODE       6'h11
`define RLNC_DEST_BIT     9
`define RLNC_BANK_BIT     8
// control bits
`define RLNC_CTRL_START   0
`define RLNC_CTRL_EXT     1
// status bits
`define RLNC_ST_BUSY      0
`define RLNC_ST_ZERO      1
`define RLNC_ST_NEG       2
`define RLNC_ST_ILLEGAL   3
`define RLNC_ST_CARRY     4
// indexed literal offset limit
`define RLNC_INDEX_MAX    8'h5F
// access bank upper half maps to bank 15
`define RLNC_ACCESS_HI    4'hF
`define RLNC_RESET_WORD   8'h00
`endif

// *** design/rlnc_exec.v ***
// Notes on behaviour
// - the instruction rotates an 8-bit data-memory byte left and never reads or changes carry.
// - result bit n+1 takes operand bit n, bit 0 takes operand bit 7, and N and Z follow the result.
// - the decoder takes an 8-bit file address plus one destination bit and one bank-access bit.
// - bank-access 0 selects the fixed access bank, 1 takes the upper address bits from the bank select reg.
// - bank-access 0 with extended set on and address at most 5Fh uses indexed literal-offset addressing.
// - the instruction runs in four phases: decode, read operand, rotate, write destination.
// - destination 1 writes the file register, destination 0 writes the working register.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "rlnc_defines.vh"
module rlnc_exec #(
  parameter MEM_DEPTH = 4096,
  parameter ADDR_W    = 12
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         busy,
  output reg         done
);

  localparam PH_IDLE = 5'b00001;
  localparam PH_Q1   = 5'b00010;
  localparam PH_Q2   = 5'b00100;
  localparam PH_Q3   = 5'b01000;
  localparam PH_Q4   = 5'b10000;

  reg [7:0]        dataMem [0:MEM_DEPTH-1];
  reg [4:0]        phase;
  reg [4:0]        next_phase;
  reg [15:0]       instrWord;
  reg              extEnable;
  reg [7:0]        wreg;
  reg [3:0]        bankSelect;
  reg [ADDR_W-1:0] indexBase;
  reg [ADDR_W-1:0] memAddrPtr;
  reg              flagZero;
  reg              flagNeg;
  reg              flagCarry;
  reg              illegal;
  reg              destFile;
  reg [ADDR_W-1:0] effAddr;
  reg [7:0]        operand;
  reg [7:0]        result;
  reg [ADDR_W-1:0] next_effAddr;
  reg [31:0]       next_prdata;
  reg              next_pslverr;

  wire       accessDone = psel && penable && pready;
  wire [7:0] rotated;

  // one-hot register select, shared by every write strobe below
  function [7:0] regDecode;
    input [11:0] a;
    begin
      case (a)
        `RLNC_CTRL_OFF:    regDecode = 8'h01;
        `RLNC_INSTR_OFF:   regDecode = 8'h02;
        `RLNC_STATUS_OFF:  regDecode = 8'h04;
        `RLNC_WREG_OFF:    regDecode = 8'h08;
        `RLNC_BANK_OFF:    regDecode = 8'h10;
        `RLNC_MEMADDR_OFF: regDecode = 8'h20;
        `RLNC_MEMDATA_OFF: regDecode = 8'h40;
        `RLNC_INDEX_OFF:   regDecode = 8'h80;
        default:           regDecode = 8'h00;
      endcase
    end
  endfunction

  function isRotate;
    input [15:0] w;
    begin
      isRotate = (w[`RLNC_OPC_HI:`RLNC_OPC_LO] == `RLNC_OPCODE);
    end
  endfunction

  // writes land only while idle, so a running instruction never sees its operands move
  wire [7:0] regSel    = regDecode(paddr);
  wire       busWrite  = accessDone && pwrite && (phase == PH_IDLE);
  wire       wrCtrl    = busWrite && regSel[0];
  wire       wrInstr   = busWrite && regSel[1];
  wire       wrStatus  = busWrite && regSel[2];
  wire       wrWreg    = busWrite && regSel[3];
  wire       wrBank    = busWrite && regSel[4];
  wire       wrMemAddr = busWrite && regSel[5];
  wire       wrMemData = busWrite && regSel[6];
  wire       wrIndex   = busWrite && regSel[7];
  wire       startReq  = wrCtrl && pwdata[`RLNC_CTRL_START];

  // rotate network: bit n moves to n+1 and bit 7 wraps to bit 0
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : rotBit
      assign rotated[(gi + 1) % 8] = operand[gi];
    end
  endgenerate

  // operand address from the three addressing options
  always @* begin
    next_effAddr = {ADDR_W{1'b0}};
    if (instrWord[`RLNC_BANK_BIT]) begin
      next_effAddr = {bankSelect, instrWord[7:0]};
    end else if (extEnable && instrWord[7:0] <= `RLNC_INDEX_MAX) begin
      next_effAddr = indexBase + {{(ADDR_W-8){1'b0}}, instrWord[7:0]};
    end else if (instrWord[7]) begin
      next_effAddr = {`RLNC_ACCESS_HI, instrWord[7:0]};
    end else begin
      next_effAddr = {4'h0, instrWord[7:0]};
    end
  end

  always @* begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    case (paddr)
      `RLNC_CTRL_OFF:    next_prdata = {30'h0, extEnable, 1'b0};
      `RLNC_INSTR_OFF:   next_prdata = {16'h0, instrWord};
      `RLNC_STATUS_OFF:  next_prdata = {27'h0, flagCarry, illegal, flagNeg, flagZero, busy};
      `RLNC_WREG_OFF:    next_prdata = {24'h0, wreg};
      `RLNC_BANK_OFF:    next_prdata = {28'h0, bankSelect};
      `RLNC_MEMADDR_OFF: next_prdata = {{(32-ADDR_W){1'b0}}, memAddrPtr};
      `RLNC_MEMDATA_OFF: next_prdata = {24'h0, dataMem[memAddrPtr]};
      `RLNC_INDEX_OFF:   next_prdata = {{(32-ADDR_W){1'b0}}, indexBase};
      default:           next_pslverr = 1'b1;
    endcase
  end

  // no wait state: ready rises in the first access cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= next_pslverr;
        if (!pwrite) begin
          prdata <= next_prdata;
        end
      end
    end
  end

  // phase sequencer: one cycle per quarter, a bad word ends it right after decode
  always @* begin
    next_phase = PH_IDLE;
    case (phase)
      PH_IDLE: begin
        next_phase = startReq ? PH_Q1 : PH_IDLE;
      end
      PH_Q1: begin
        next_phase = isRotate(instrWord) ? PH_Q2 : PH_IDLE;
      end
      PH_Q2: begin
        next_phase = PH_Q3;
      end
      PH_Q3: begin
        next_phase = PH_Q4;
      end
      PH_Q4: begin
        next_phase = PH_IDLE;
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // bus-only configuration registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      extEnable <= 1'b0;
    end else if (wrCtrl) begin
      extEnable <= pwdata[`RLNC_CTRL_EXT];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      instrWord <= 16'h0000;
    end else if (wrInstr) begin
      instrWord <= pwdata[15:0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bankSelect <= 4'h0;
    end else if (wrBank) begin
      bankSelect <= pwdata[3:0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      indexBase <= {ADDR_W{1'b0}};
    end else if (wrIndex) begin
      indexBase <= pwdata[ADDR_W-1:0];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      memAddrPtr <= {ADDR_W{1'b0}};
    end else if (wrMemAddr) begin
      memAddrPtr <= pwdata[ADDR_W-1:0];
    end
  end

  // instruction datapath and the busy/done handshake
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      illegal  <= 1'b0;
      destFile <= 1'b0;
      effAddr  <= {ADDR_W{1'b0}};
      operand  <= 8'h00;
      result   <= 8'h00;
      busy     <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      case (phase)
        PH_IDLE: begin
          if (startReq) begin
            busy <= 1'b1;
          end
        end
        PH_Q1: begin
          if (isRotate(instrWord)) begin
            illegal  <= 1'b0;
            destFile <= instrWord[`RLNC_DEST_BIT];
            effAddr  <= next_effAddr;
          end else begin
            illegal <= 1'b1;
            busy    <= 1'b0;
            done    <= 1'b1;
          end
        end
        PH_Q2: begin
          operand <= dataMem[effAddr];
        end
        PH_Q3: begin
          result <= rotated;
        end
        PH_Q4: begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        default: begin
          busy <= 1'b0;
        end
      endcase
    end
  end

  // only Q4 of a good word moves N and Z; carry is left to the bus alone
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flagZero  <= 1'b0;
      flagNeg   <= 1'b0;
      flagCarry <= 1'b0;
    end else begin
      if (phase == PH_Q4) begin
        flagZero <= (result == 8'h00);
        flagNeg  <= result[7];
      end
      if (wrStatus) begin
        flagCarry <= pwdata[`RLNC_ST_CARRY];
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wreg <= `RLNC_RESET_WORD;
    end else if (phase == PH_Q4 && !destFile) begin
      wreg <= result;
    end else if (wrWreg) begin
      wreg <= pwdata[7:0];
    end
  end

  // memory has two writers arbitrated by phase: bus when idle, write-back in Q4
  always @(posedge clk) begin
    if (phase == PH_Q4 && destFile) begin
      dataMem[effAddr] <= result;
    end else if (wrMemData) begin
      dataMem[memAddrPtr] <= pwdata[7:0];
    end
  end

endmodule

// *** verification/rlnc_exec_checker.sv ***
`timescale 1ns/1ps
module rlnc_exec_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        busy,
  input wire logic        done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] instrSeen;
  logic        carrySeen;
  wire         wrAcc    = psel && penable && pready && pwrite && !busy;
  wire         startWr  = wrAcc && paddr == 12'h000 && pwdata[0];
  wire         statusRd = psel && penable && pready && !pwrite && paddr == 12'h008;
  wire         legal    = instrSeen[15:10] == 6'h11;
  // shadows of what software wrote; writes while busy are ignored by the block
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      instrSeen <= 16'h0000;
      carrySeen <= 1'b0;
    end else begin
      if (wrAcc && paddr == 12'h004) instrSeen <= pwdata[15:0];
      if (wrAcc && paddr == 12'h008) carrySeen <= pwdata[4];
    end
  end
  sequence exec_s;
    busy [*4] ##1 (!busy && done);
  endsequence
  sequence reject_s;
    busy ##1 (!busy && done);
  endsequence
  start_exec_a: assert property (startWr && legal |=> exec_s) else $error("start missed four phases");
  busy_phase_a: assert property ($rose(busy) && legal |-> exec_s) else $error("busy not four cycles");
  bad_word_a: assert property (startWr && !legal |=> reject_s) else $error("bad word not rejected");
  carry_kept_a: assert property (statusRd |-> prdata[4] == carrySeen) else $error("carry changed by instruction");
  done_pulse_a: assert property (done |=> !done) else $error("done longer than one cycle");
  done_end_a: assert property (done |-> $past(busy) && !busy) else $error("done without busy");
  busy_fall_a: assert property ($fell(busy) |-> done) else $error("busy ended without done");
  cover property (startWr);
endmodule

// *** verification/rlnc_apb_bfm.sv ***
`timescale 1ns/1ps
module rlnc_apb_bfm (
  input  wire         clk,
  input  wire         pready,
  output logic        psel = 1'b0,
  output logic        penable = 1'b0,
  output logic        pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0
);
  // one idle edge first, so a release and a new setup never share a time step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 50);
    if (n >= 50) tb_rlnc_exec.summarize(1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// *** verification/tb_rlnc_exec.sv ***
`timescale 1ns/1ps
module tb_rlnc_exec;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, busy, done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] expq[$];
  int          n_errors = 0;
  int          compares = 0;
  always #20 clk = ~clk;
  rlnc_apb_bfm bfm_u (.clk(clk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  rlnc_exec dut_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .done(done));
  task automatic summarize(input int hung);
    n_errors += hung;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clk)
    if (psel && penable && pready && !pwrite) check({pslverr, pslverr ? 32'h0 : prdata}, expq.pop_front());
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    bfm_u.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bfm_u.xfer(1'b1, a, d);
  endtask
  task automatic await_done();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!done && n < 20);
    if (!done) summarize(1);
  endtask
  initial begin
    logic [7:0] op, f, res;
    logic [3:0] bank;
    logic [11:0] idx, ad;
    logic d, a, x;
    int n;
    n = $urandom(28);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd(12'h020, 33'h1_0000_0000);
    wr(12'h008, 32'h10);
    for (int i = 0; i < 24; i++) begin
      op = (i < 4) ? {i[0], 6'h00, i[1]} : 8'($urandom);
      f = (i == 4) ? 8'h5F : 8'($urandom);
      bank = 4'($urandom);
      idx = {4'h0, 8'($urandom)};
      {x, a, d} = 3'(i);
      ad = a ? {bank, f} : ((x && f <= 8'h5F) ? idx + {4'h0, f} : {f[7] ? 4'hF : 4'h0, f});
      res = {op[6:0], op[7]};
      wr(12'h000, {30'h0, x, 1'b0});
      wr(12'h010, {28'h0, bank});
      wr(12'h01C, {20'h0, idx});
      wr(12'h014, {20'h0, ad});
      wr(12'h018, {24'h0, op});
      wr(12'h00C, {24'h0, ~res});
      wr(12'h004, {16'h0, 6'h11, d, a, f});
      wr(12'h000, {30'h0, x, 1'b1});
      await_done();
      rd(12'h00C, {25'h0, d ? ~res : res});
      rd(12'h018, {25'h0, d ? res : op});
      rd(12'h008, {27'h0, 1'b1, 1'b0, res[7], res == 8'h00, 1'b0});
      $display("test %0d op %h ended", i, op);
    end
    wr(12'h004, {16'h0, 6'h10, d, a, f});
    wr(12'h000, {30'h0, x, 1'b1});
    await_done();
    rd(12'h008, {27'h0, 1'b1, 1'b1, res[7], res == 8'h00, 1'b0});
    rd(12'h00C, {25'h0, d ? ~res : res});
    rd(12'h018, {25'h0, d ? res : op});
    $display("test illegal word ended");
    summarize(0);
  end
endmodule
bind rlnc_exec rlnc_exec_checker chk_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .done(done));
